/* tpf_tx_framer.sv */
// Functional notes
// - headers only inserted while automatic packet handling is enabled.
// - header bytes go out highest numbered first.
// - fixed-length flag set drops the length byte; clear sends it.
// - sync length code 0..3 sends sync byte 3 down to byte 3 minus the code.
// - sync bytes go out in descending order, byte 3 first.
// - preamble length is 9-bit nibble count; msb in header control bit 0.
// - preamble length zero behaves as one nibble.
// - low preamble length resets to eight nibbles.
// - sync bytes reset to 2d, d4, 00, 00.
// - four header registers map header 3..0 and reset to zero.
// - packet length register is payload size in bytes, 0 to 255.
// - packet length zero sends no payload bytes.
// - framing only with packet enable in fifo mode; packet enable clear sends raw fifo contents; outside fifo mode nothing starts.
// - crc enable appends crc; two-bit selector picks the polynomial.
// - crc data-only computes crc over payload only.
// - low-bit-first sends each byte lsb first except the crc bytes, which always go msb first; else msb first.
`timescale 1ns/1ps
module tpf_tx_framer #(
  parameter int unsigned PRE_LEN_W = 9
) (
  input wire logic mclk, // 100 MHz clock
  input wire logic rst_n, // async reset, active low
  input wire tpf_pkg::tpf_bus_req_s bus_req, // register access
  output logic [7:0] rd_data, // read data, cycle after read strobe
  input wire logic fifo_mode, // modulation source is the fifo
  input wire logic tx_start, // start one transmission, pulse
  input wire logic [7:0] fifo_data, // head of tx fifo
  input wire logic fifo_valid, // fifo not empty
  output logic fifo_pop, // fifo head taken, pulse
  input wire logic bit_req, // modulator wants next bit, pulse
  output logic tx_bit, // serial bit to modulator
  output logic tx_bit_valid, // tx_bit updated, pulse
  output logic pkt_tx, // packet being transmitted
  output logic pkt_sent // packet sent, sticky until next start
);
  import tpf_pkg::*;

  generate
    if (PRE_LEN_W != 9)
    begin : g_chk
      $error("tpf_tx_framer preamble length width must be 9");
    end
  endgenerate

  // reset release
  logic [1:0] rst_pipe;
  logic rst_s_n;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rst_pipe <= 2'b00;
    else
      rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign rst_s_n = rst_pipe[1];

  // register file
  logic [7:0] data_ctrl, hdr_ctrl, pre_len_lo, pklen;
  logic [3:0][7:0] sync_word, hdr_word;
  logic [7:0] next_data_ctrl, next_hdr_ctrl, next_pre_len_lo, next_pklen, next_rd_data;
  logic [3:0][7:0] next_sync_word, next_hdr_word;

  always_comb
  begin
    next_data_ctrl = data_ctrl;
    next_hdr_ctrl = hdr_ctrl;
    next_pre_len_lo = pre_len_lo;
    next_pklen = pklen;
    next_sync_word = sync_word;
    next_hdr_word = hdr_word;
    if (bus_req.wr)
    begin
      case (bus_req.addr)
        ADR_DATA_CTRL: next_data_ctrl = bus_req.wdata;
        ADR_HDR_CTRL: next_hdr_ctrl = bus_req.wdata & HDR_CTRL_MASK;
        ADR_PRE_LEN: next_pre_len_lo = bus_req.wdata;
        ADR_SYNC3: next_sync_word[3] = bus_req.wdata;
        ADR_SYNC2: next_sync_word[2] = bus_req.wdata;
        ADR_SYNC1: next_sync_word[1] = bus_req.wdata;
        ADR_SYNC0: next_sync_word[0] = bus_req.wdata;
        ADR_HDR3: next_hdr_word[3] = bus_req.wdata;
        ADR_HDR2: next_hdr_word[2] = bus_req.wdata;
        ADR_HDR1: next_hdr_word[1] = bus_req.wdata;
        ADR_HDR0: next_hdr_word[0] = bus_req.wdata;
        ADR_PKLEN: next_pklen = bus_req.wdata;
        default: next_pklen = pklen;
      endcase
    end
    next_rd_data = 8'h00;
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        ADR_DATA_CTRL: next_rd_data = data_ctrl;
        ADR_STATUS: next_rd_data = {6'h00, pkt_tx, pkt_sent};
        ADR_HDR_CTRL: next_rd_data = hdr_ctrl;
        ADR_PRE_LEN: next_rd_data = pre_len_lo;
        ADR_SYNC3: next_rd_data = sync_word[3];
        ADR_SYNC2: next_rd_data = sync_word[2];
        ADR_SYNC1: next_rd_data = sync_word[1];
        ADR_SYNC0: next_rd_data = sync_word[0];
        ADR_HDR3: next_rd_data = hdr_word[3];
        ADR_HDR2: next_rd_data = hdr_word[2];
        ADR_HDR1: next_rd_data = hdr_word[1];
        ADR_HDR0: next_rd_data = hdr_word[0];
        ADR_PKLEN: next_rd_data = pklen;
        default: next_rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      data_ctrl <= RST_DATA_CTRL;
      hdr_ctrl <= RST_HDR_CTRL;
      pre_len_lo <= RST_PRE_LEN;
      sync_word <= {RST_SYNC3, RST_SYNC2, RST_SYNC1, RST_SYNC0};
      hdr_word <= {RST_HDR, RST_HDR, RST_HDR, RST_HDR};
      pklen <= RST_PKLEN;
      rd_data <= 8'h00;
    end
    else
    begin
      data_ctrl <= next_data_ctrl;
      hdr_ctrl <= next_hdr_ctrl;
      pre_len_lo <= next_pre_len_lo;
      sync_word <= next_sync_word;
      hdr_word <= next_hdr_word;
      pklen <= next_pklen;
      rd_data <= next_rd_data;
    end
  end

  // configuration decode
  logic low_bit_first, crc_data_only, pkt_en, crc_en, fix_len;
  logic [1:0] crc_sel, sync_len;
  logic [2:0] hdr_len;
  logic [PRE_LEN_W-1:0] pre_len;
  assign low_bit_first = data_ctrl[BIT_LOW_BIT_FIRST];
  assign crc_data_only = data_ctrl[BIT_CRC_DATA_ONLY];
  assign pkt_en = data_ctrl[BIT_PKT_EN];
  assign crc_en = data_ctrl[BIT_CRC_EN];
  assign crc_sel = data_ctrl[CRC_SEL_LSB +: 2];
  assign hdr_len = hdr_ctrl[HDLEN_LSB +: 3];
  assign fix_len = hdr_ctrl[BIT_FIX_LEN];
  assign sync_len = hdr_ctrl[SYNCLEN_LSB +: 2];
  assign pre_len = {hdr_ctrl[BIT_PRE_MSB], pre_len_lo};

  // framer state
  tpf_state_e state, next_state;
  logic [7:0] idx, next_idx, field_cnt, field_byte;
  logic [10:0] pre_cnt, next_pre_cnt;
  logic next_tx_bit, next_tx_bit_valid, next_pkt_tx, next_pkt_sent;
  logic byte_state, byte_avail, have_bit, take, ser_load, ser_bit, ser_empty;
  logic crc_clear, crc_take;
  logic [CRC_W-1:0] crc;

  always_comb
  begin
    case (state)
      TPF_SYNC: field_cnt = {6'h00, sync_len} + 8'h01;
      TPF_HDR: field_cnt = (hdr_len > HDLEN_MAX) ? 8'h04 : {5'h00, hdr_len};
      TPF_LEN: field_cnt = fix_len ? 8'h00 : 8'h01;
      TPF_PAY: field_cnt = pklen;
      TPF_CRC: field_cnt = crc_en ? 8'h02 : 8'h00;
      default: field_cnt = 8'h00;
    endcase
    case (state)
      TPF_SYNC: field_byte = sync_word[2'd3 - idx[1:0]];
      TPF_HDR: field_byte = hdr_word[2'd3 - idx[1:0]];
      TPF_LEN: field_byte = pklen;
      TPF_CRC: field_byte = (idx == 8'h00) ? crc[15:8] : crc[7:0];
      default: field_byte = fifo_data;
    endcase
  end

  assign byte_state = (state != TPF_IDLE) && (state != TPF_PRE);
  assign byte_avail = ((state == TPF_PAY) || (state == TPF_RAW)) ? fifo_valid : 1'b1;
  assign have_bit = (state == TPF_PRE) || (byte_state && !ser_empty);
  assign take = bit_req && have_bit;
  assign ser_load = byte_state && ser_empty && byte_avail
                    && ((state == TPF_RAW) || (idx < field_cnt));
  assign fifo_pop = ser_load && ((state == TPF_PAY) || (state == TPF_RAW));
  assign crc_clear = (state == TPF_IDLE);
  // crc frozen while its own bytes go out
  assign crc_take = take && ((state == TPF_PAY)
                    || (!crc_data_only && ((state == TPF_HDR) || (state == TPF_LEN))));

  always_comb
  begin
    next_state = state;
    next_idx = idx;
    next_pre_cnt = pre_cnt;
    next_tx_bit = tx_bit;
    next_tx_bit_valid = 1'b0;
    next_pkt_tx = pkt_tx;
    next_pkt_sent = pkt_sent;
    if (take)
    begin
      next_tx_bit = (state == TPF_PRE) ? ~pre_cnt[0] : ser_bit;
      next_tx_bit_valid = 1'b1;
    end
    if (ser_load)
      next_idx = idx + 8'h01;
    case (state)
      TPF_IDLE:
      begin
        next_idx = 8'h00;
        if (tx_start && fifo_mode)
        begin
          next_pkt_tx = 1'b1;
          next_pkt_sent = 1'b0;
          // zero nibbles sent as one
          next_pre_cnt = {(pre_len == '0) ? 9'h001 : pre_len, 2'b00};
          next_state = pkt_en ? TPF_PRE : TPF_RAW;
        end
      end
      TPF_PRE:
      begin
        if (take)
        begin
          next_pre_cnt = pre_cnt - 11'h001;
          if (pre_cnt == 11'h001)
            next_state = TPF_SYNC;
        end
      end
      TPF_SYNC, TPF_HDR, TPF_LEN, TPF_PAY, TPF_CRC:
      begin
        if (ser_empty && (idx == field_cnt))
        begin
          next_idx = 8'h00;
          case (state)
            TPF_SYNC: next_state = TPF_HDR;
            TPF_HDR: next_state = TPF_LEN;
            TPF_LEN: next_state = TPF_PAY;
            TPF_PAY: next_state = TPF_CRC;
            default:
            begin
              next_state = TPF_IDLE;
              next_pkt_tx = 1'b0;
              next_pkt_sent = 1'b1;
            end
          endcase
        end
      end
      TPF_RAW:
      begin
        if (ser_empty && !fifo_valid)
        begin
          next_state = TPF_IDLE;
          next_pkt_tx = 1'b0;
          next_pkt_sent = 1'b1;
        end
      end
      default: next_state = TPF_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      state <= TPF_IDLE;
      idx <= 8'h00;
      pre_cnt <= 11'h000;
      tx_bit <= 1'b0;
      tx_bit_valid <= 1'b0;
      pkt_tx <= 1'b0;
      pkt_sent <= 1'b0;
    end
    else
    begin
      state <= next_state;
      idx <= next_idx;
      pre_cnt <= next_pre_cnt;
      tx_bit <= next_tx_bit;
      tx_bit_valid <= next_tx_bit_valid;
      pkt_tx <= next_pkt_tx;
      pkt_sent <= next_pkt_sent;
    end
  end

  tpf_serializer #(
    .WIDTH(BYTE_W)
  ) u_ser (
    .mclk(mclk),
    .rst_s_n(rst_s_n),
    .load(ser_load),
    .word(field_byte),
    .low_first(low_bit_first && (state != TPF_CRC)),
    .shift(take && (state != TPF_PRE)),
    .bit_now(ser_bit),
    .empty(ser_empty)
  );

  tpf_crc #(
    .WIDTH(CRC_W)
  ) u_crc (
    .mclk(mclk),
    .rst_s_n(rst_s_n),
    .clear(crc_clear),
    .en(crc_take),
    .bit_in(ser_bit),
    .poly(CRC_POLY[crc_sel]),
    .seed(CRC_SEED[crc_sel]),
    .crc(crc)
  );
endmodule

/* tpf_pkg.sv */
package tpf_pkg;

  localparam int unsigned ADDR_W = 7;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned CRC_W = 16;
  localparam int unsigned NIBBLE_BITS = 4;
  localparam int unsigned SER_CNT_W = 4;

  // register offsets
  localparam logic [6:0] ADR_DATA_CTRL = 7'h30;
  localparam logic [6:0] ADR_STATUS = 7'h31;
  localparam logic [6:0] ADR_HDR_CTRL = 7'h33;
  localparam logic [6:0] ADR_PRE_LEN = 7'h34;
  localparam logic [6:0] ADR_SYNC3 = 7'h36;
  localparam logic [6:0] ADR_SYNC2 = 7'h37;
  localparam logic [6:0] ADR_SYNC1 = 7'h38;
  localparam logic [6:0] ADR_SYNC0 = 7'h39;
  localparam logic [6:0] ADR_HDR3 = 7'h3a;
  localparam logic [6:0] ADR_HDR2 = 7'h3b;
  localparam logic [6:0] ADR_HDR1 = 7'h3c;
  localparam logic [6:0] ADR_HDR0 = 7'h3d;
  localparam logic [6:0] ADR_PKLEN = 7'h3e;

  // data access control fields
  localparam int unsigned BIT_LOW_BIT_FIRST = 6;
  localparam int unsigned BIT_CRC_DATA_ONLY = 5;
  localparam int unsigned BIT_PKT_EN = 3;
  localparam int unsigned BIT_CRC_EN = 2;
  localparam int unsigned CRC_SEL_LSB = 0;
  // header control fields
  localparam int unsigned HDLEN_LSB = 4;
  localparam int unsigned BIT_FIX_LEN = 3;
  localparam int unsigned SYNCLEN_LSB = 1;
  localparam int unsigned BIT_PRE_MSB = 0;
  localparam logic [7:0] HDR_CTRL_MASK = 8'h7f;
  localparam logic [2:0] HDLEN_MAX = 3'h4;

  // reset values
  localparam logic [7:0] RST_DATA_CTRL = 8'h00;
  localparam logic [7:0] RST_HDR_CTRL = 8'h00;
  localparam logic [7:0] RST_PRE_LEN = 8'h08;
  localparam logic [7:0] RST_SYNC3 = 8'h2d;
  localparam logic [7:0] RST_SYNC2 = 8'hd4;
  localparam logic [7:0] RST_SYNC1 = 8'h00;
  localparam logic [7:0] RST_SYNC0 = 8'h00;
  localparam logic [7:0] RST_HDR = 8'h00;
  localparam logic [7:0] RST_PKLEN = 8'h00;

  // crc polynomial and seed per selector code
  localparam logic [3:0][15:0] CRC_POLY = {16'h6f63, 16'h3d65, 16'h8005, 16'h1021};
  localparam logic [3:0][15:0] CRC_SEED = {16'hffff, 16'h0000, 16'h0000, 16'hffff};

  typedef enum logic [7:0] {
    TPF_IDLE = 8'b0000_0001,
    TPF_PRE = 8'b0000_0010,
    TPF_SYNC = 8'b0000_0100,
    TPF_HDR = 8'b0000_1000,
    TPF_LEN = 8'b0001_0000,
    TPF_PAY = 8'b0010_0000,
    TPF_CRC = 8'b0100_0000,
    TPF_RAW = 8'b1000_0000
  } tpf_state_e;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tpf_bus_req_s;

endpackage

/* tpf_crc.sv */
`timescale 1ns/1ps
module tpf_crc #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic mclk, // clock
  input wire logic rst_s_n, // synchronised reset
  input wire logic clear, // load seed
  input wire logic en, // absorb one bit
  input wire logic bit_in, // serial data bit
  input wire logic [WIDTH-1:0] poly, // polynomial
  input wire logic [WIDTH-1:0] seed, // start value
  output logic [WIDTH-1:0] crc // running remainder
);
  generate
    if (WIDTH < 2)
    begin : g_chk
      $error("tpf_crc width too small");
    end
  endgenerate

  logic [WIDTH-1:0] next_crc;
  logic fb;

  always_comb
  begin
    fb = crc[WIDTH-1] ^ bit_in;
    next_crc = crc;
    if (clear)
    begin
      next_crc = seed;
    end
    else if (en)
    begin
      next_crc = {crc[WIDTH-2:0], 1'b0} ^ (fb ? poly : '0);
    end
  end

  always_ff @(posedge mclk or negedge rst_s_n)
  begin
    if (!rst_s_n)
      crc <= '0;
    else
      crc <= next_crc;
  end
endmodule

/* tpf_serializer.sv */
`timescale 1ns/1ps
module tpf_serializer #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic mclk, // clock
  input wire logic rst_s_n, // synchronised reset
  input wire logic load, // take a new word, only while empty
  input wire logic [WIDTH-1:0] word, // word to send
  input wire logic low_first, // send bit 0 first
  input wire logic shift, // current bit consumed
  output logic bit_now, // bit on offer
  output logic empty // no bit on offer
);
  generate
    if (WIDTH < 2 || WIDTH > 15)
    begin : g_chk
      $error("tpf_serializer width out of range");
    end
  endgenerate

  logic [WIDTH-1:0] sr;
  logic [3:0] left;
  logic lsb;
  logic [WIDTH-1:0] next_sr;
  logic [3:0] next_left;
  logic next_lsb;

  assign empty = (left == 4'h0);
  assign bit_now = lsb ? sr[0] : sr[WIDTH-1];

  always_comb
  begin
    next_sr = sr;
    next_left = left;
    next_lsb = lsb;
    if (load)
    begin
      next_sr = word;
      next_left = 4'(WIDTH);
      next_lsb = low_first;
    end
    else if (shift && !empty)
    begin
      next_sr = lsb ? {1'b0, sr[WIDTH-1:1]} : {sr[WIDTH-2:0], 1'b0};
      next_left = left - 4'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      sr <= '0;
      left <= 4'h0;
      lsb <= 1'b0;
    end
    else
    begin
      sr <= next_sr;
      left <= next_left;
      lsb <= next_lsb;
    end
  end
endmodule

/* tpf_tx_framer_chk.sv */
`timescale 1ns/1ps
module tpf_tx_framer_chk #(
  parameter int unsigned PRE_LEN_W = 9
) (
  input wire logic mclk, // clock
  input wire logic rst_n, // reset
  input wire tpf_pkg::tpf_bus_req_s bus_req, // bus
  input wire logic [7:0] rd_data, // read data
  input wire logic fifo_mode, // fifo source
  input wire logic tx_start, // start
  input wire logic [7:0] fifo_data, // fifo head
  input wire logic fifo_valid, // fifo ready
  input wire logic fifo_pop, // fifo taken
  input wire logic bit_req, // bit wanted
  input wire logic tx_bit, // bit
  input wire logic tx_bit_valid, // bit strobe
  input wire logic pkt_tx, // busy
  input wire logic pkt_sent // done
);
  import tpf_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic pkt_tx_d, first, next_first, pkt_on, next_pkt_on;
  // first bit of a packet still to come
  always_comb
  begin
    next_first = (pkt_tx && !pkt_tx_d) || (first && !tx_bit_valid);
    // framing enable as last written; raw frames carry no preamble
    next_pkt_on = pkt_on;
    if (bus_req.wr && (bus_req.addr == ADR_DATA_CTRL))
      next_pkt_on = bus_req.wdata[BIT_PKT_EN];
  end
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pkt_tx_d <= 1'b0;
      first <= 1'b0;
      pkt_on <= 1'b0;
    end
    else
    begin
      pkt_tx_d <= pkt_tx;
      first <= next_first;
      pkt_on <= next_pkt_on;
    end
  end
  property p_pre_first;
    first && pkt_on && tx_bit_valid |-> tx_bit;
  endproperty
  a_pre_first: assert property (p_pre_first) else $error("preamble must open with one");
  property p_sent_end;
    $fell(pkt_tx) |-> ##[0:2] pkt_sent;
  endproperty
  a_sent_end: assert property (p_sent_end) else $error("sent flag missing at end");
  property p_sent_cause;
    $rose(pkt_sent) |-> !pkt_tx;
  endproperty
  a_sent_cause: assert property (p_sent_cause) else $error("sent while busy");
  property p_start;
    $rose(pkt_tx) |-> !pkt_sent && $past(tx_start && fifo_mode);
  endproperty
  a_start: assert property (p_start) else $error("bad start of packet");
  property p_mode_off;
    tx_start && !fifo_mode && !pkt_tx |=> !pkt_tx;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("start taken outside fifo mode");
  property p_bit_cause;
    tx_bit_valid |-> $past(bit_req) && !$past(tx_bit_valid);
  endproperty
  a_bit_cause: assert property (p_bit_cause) else $error("bit strobe without request");
  property p_bit_hold;
    !tx_bit_valid |-> $stable(tx_bit);
  endproperty
  a_bit_hold: assert property (p_bit_hold) else $error("bit changed without strobe");
  property p_pop;
    fifo_pop |-> fifo_valid;
  endproperty
  a_pop: assert property (p_pop) else $error("pop from empty fifo");
  property p_status;
    $past(bus_req.rd && bus_req.addr == ADR_STATUS) |->
      rd_data == {6'h00, $past(pkt_tx), $past(pkt_sent)};
  endproperty
  a_status: assert property (p_status) else $error("status read wrong");
  c_start: cover property ($rose(pkt_tx));
  c_sent: cover property ($rose(pkt_sent));
  c_pop: cover property (fifo_pop);
endmodule

/* tpf_far_model.sv */
`timescale 1ns/1ps
module tpf_far_model (
  input wire logic mclk, // clock
  input wire logic fifo_pop, // head taken
  output logic [7:0] fifo_data, // head byte
  output logic fifo_valid, // not empty
  output logic bit_req // next bit wanted
);
  logic [7:0] mem[$];
  logic [7:0] last;
  logic v;
  bit slow;
  int cnt, gap;
  initial
  begin
    last = 8'h00;
    slow = 1'b0;
    cnt = 0;
    gap = 3;
    fifo_data = 8'hff;
    fifo_valid = 1'b0;
    bit_req = 1'b0;
  end
  // slow mode stalls the fifo and spaces requests unevenly
  always @(posedge mclk)
  begin
    if (fifo_pop && mem.size() != 0)
      last = mem.pop_front();
    v = (mem.size() != 0) && !(slow && $urandom_range(3) == 0);
    fifo_valid <= v;
    fifo_data <= v ? mem[0] : ~last;
    cnt = cnt + 1;
    bit_req <= (cnt >= gap);
    if (cnt >= gap)
    begin
      cnt = 0;
      gap = slow ? 3 + $urandom_range(5) : 3;
    end
  end
endmodule

/* tpf_tx_framer_tb.sv */
`timescale 1ns/1ps
module tpf_tx_framer_tb;
  import tpf_pkg::*;
  logic mclk, rst_n, fifo_mode, tx_start, fifo_pop, bit_req, fifo_valid;
  logic tx_bit, tx_bit_valid, pkt_tx, pkt_sent, rd_prev;
  logic [7:0] rd_data, fifo_data;
  tpf_bus_req_s bus_req;
  logic [7:0] rq[$];
  logic bq[$];
  logic [15:0] crc;
  int err_total, checks;
  tpf_tx_framer #(.PRE_LEN_W(9)) dut (.mclk(mclk), .rst_n(rst_n), .bus_req(bus_req),
    .rd_data(rd_data), .fifo_mode(fifo_mode), .tx_start(tx_start), .fifo_data(fifo_data),
    .fifo_valid(fifo_valid), .fifo_pop(fifo_pop), .bit_req(bit_req), .tx_bit(tx_bit),
    .tx_bit_valid(tx_bit_valid), .pkt_tx(pkt_tx), .pkt_sent(pkt_sent));
  tpf_far_model far (.mclk(mclk), .fifo_pop(fifo_pop), .fifo_data(fifo_data),
    .fifo_valid(fifo_valid), .bit_req(bit_req));
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cmp(logic [7:0] a, logic [7:0] e);
    checks++;
    if (a !== e)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, a, e);
    end
  endtask
  task automatic cyc(int n = 1);
    repeat (n) @(posedge mclk);
  endtask
  // one bus access; a read notes its expected byte
  task automatic acc(logic w, logic [6:0] a, logic [7:0] d);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    cyc();
    if (!w)
      rq.push_back(d);
    bus_req <= '0;
    cyc();
  endtask
  task automatic eb(logic [7:0] b, logic lsb, logic c, logic [15:0] p);
    logic x;
    for (int i = 0; i < 8; i++)
    begin
      x = lsb ? b[i] : b[7-i];
      bq.push_back(x);
      if (c)
        crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ x) ? p : 16'h0000);
    end
  endtask
  task automatic go;
    tx_start <= 1'b1;
    cyc();
    tx_start <= 1'b0;
  endtask
  task automatic wt;
    for (int t = 0; t < 9000 && bq.size() != 0; t++)
      cyc();
    cmp(8'(bq.size() != 0), 8'h00);
    cyc(4);
  endtask
  task automatic pkt(int i);
    logic [8:0] pre;
    logic [1:0] sl, sel;
    logic [2:0] hl;
    logic fix, lsb, don, cen;
    logic [7:0] n, b;
    logic [7:0] sy[4];
    logic [7:0] hd[4];
    pre = (i == 0) ? 9'h000 : (i == 7) ? 9'h101 : 9'(i + 1);
    sl = 2'(i);
    sel = 2'(i);
    hl = (i == 5) ? 3'h7 : 3'(i % 5);
    fix = i[0];
    lsb = i[1];
    don = i[2];
    cen = (i != 3);
    n = (i == 1) ? 8'h00 : (i == 6) ? 8'hff : 8'(i + 2);
    for (int k = 0; k < 4; k++)
    begin
      sy[k] = 8'($urandom);
      hd[k] = 8'($urandom);
      acc(1'b1, 7'(ADR_SYNC3 + 3 - k), sy[k]);
      acc(1'b1, 7'(ADR_HDR3 + 3 - k), hd[k]);
    end
    acc(1'b1, ADR_DATA_CTRL, {1'b0, lsb, don, 1'b0, 1'b1, cen, sel});
    acc(1'b1, ADR_HDR_CTRL, {1'b0, hl, fix, sl, pre[8]});
    acc(1'b1, ADR_PRE_LEN, pre[7:0]);
    acc(1'b1, ADR_PKLEN, n);
    for (int j = 0; j < ((pre == 0) ? 4 : 4 * pre); j++)
      bq.push_back(!j[0]);
    for (int k = 3; k >= 3 - int'(sl); k--)
      eb(sy[k], lsb, 1'b0, 16'h0000);
    crc = CRC_SEED[sel];
    for (int k = 3; k > 3 - ((hl > 3'h4) ? 4 : int'(hl)); k--)
      eb(hd[k], lsb, !don, CRC_POLY[sel]);
    if (!fix)
      eb(n, lsb, !don, CRC_POLY[sel]);
    for (int k = 0; k < n; k++)
    begin
      b = 8'($urandom);
      far.mem.push_back(b);
      eb(b, lsb, 1'b1, CRC_POLY[sel]);
    end
    for (int k = 15; k >= 0 && cen; k--)
      bq.push_back(crc[k]);
    far.slow = i[0];
    go();
    cyc(6);
    go();
    acc(1'b0, ADR_STATUS, 8'h02);
    wt();
    acc(1'b0, ADR_STATUS, 8'h01);
  endtask
  always @(posedge mclk)
  begin
    if (rd_prev)
      cmp(rd_data, rq.pop_front());
    if (tx_bit_valid === 1'b1)
      cmp(8'(tx_bit), 8'((bq.size() != 0) ? bq.pop_front() : ~tx_bit));
    rd_prev <= bus_req.rd;
  end
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial
  begin
    cyc(60000);
    err_total++;
    end_sim();
  end
  initial
  begin
    logic [7:0] b;
    logic [6:0] ra[11] = '{ADR_DATA_CTRL, ADR_STATUS, ADR_HDR_CTRL, ADR_PRE_LEN, ADR_SYNC3,
      ADR_SYNC2, ADR_SYNC1, ADR_SYNC0, ADR_HDR3, ADR_HDR0, 7'h7f};
    logic [7:0] rv[11] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h2d, 8'hd4, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00};
    rst_n = 1'b0;
    bus_req = '0;
    fifo_mode = 1'b1;
    tx_start = 1'b0;
    rd_prev = 1'b0;
    err_total = 0;
    checks = 0;
    void'($urandom(32'hf1b1));
    cyc(8);
    rst_n <= 1'b1;
    cyc(3);
    for (int k = 0; k < 11; k++)
      acc(1'b0, ra[k], rv[k]);
    for (int k = 0; k < 4; k++)
    begin
      b = 8'($urandom);
      acc(1'b1, 7'(ADR_HDR3 + k), b);
      acc(1'b0, 7'(ADR_HDR3 + k), b);
    end
    acc(1'b1, ADR_HDR_CTRL, 8'hff);
    acc(1'b0, ADR_HDR_CTRL, 8'h7f);
    acc(1'b1, ADR_STATUS, 8'hff);
    acc(1'b0, ADR_STATUS, 8'h00);
    for (int i = 0; i < 8; i++)
      pkt(i);
    far.slow = 1'b0;
    acc(1'b1, ADR_DATA_CTRL, 8'h00);
    for (int k = 0; k < 3; k++)
    begin
      b = 8'($urandom);
      far.mem.push_back(b);
      eb(b, 1'b0, 1'b0, 16'h0000);
    end
    go();
    wt();
    fifo_mode <= 1'b0;
    cyc();
    go();
    cyc(40);
    cmp(8'(pkt_tx), 8'h00);
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    cyc(3);
    acc(1'b0, ADR_PRE_LEN, 8'h08);
    acc(1'b0, ADR_SYNC2, 8'hd4);
    end_sim();
  end
endmodule
bind tpf_tx_framer tpf_tx_framer_chk #(.PRE_LEN_W(PRE_LEN_W)) chk (.mclk(mclk), .rst_n(rst_n),
  .bus_req(bus_req), .rd_data(rd_data), .fifo_mode(fifo_mode), .tx_start(tx_start),
  .fifo_data(fifo_data), .fifo_valid(fifo_valid), .fifo_pop(fifo_pop), .bit_req(bit_req),
  .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid), .pkt_tx(pkt_tx), .pkt_sent(pkt_sent));
